/* File: common/amt_pkg.sv */
package amt_pkg;

  // Addressing types
  typedef enum logic [1:0] {
    AMT_REAL     = 2'b00,
    AMT_VIRTUAL  = 2'b01,
    AMT_EXTENDED = 2'b10
  } amt_mode_e;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_INSTR    = 8'h04;
  localparam logic [7:0] OFF_INDEX    = 8'h08;
  localparam logic [7:0] OFF_INDIRECT = 8'h0C;
  localparam logic [7:0] OFF_MAP_OLD  = 8'h10;
  localparam logic [7:0] OFF_MAP_FULL = 8'h14;
  localparam logic [7:0] OFF_STACK    = 8'h18;
  localparam logic [7:0] OFF_STR_SRC  = 8'h1C;
  localparam logic [7:0] OFF_STR_DST  = 8'h20;
  localparam logic [7:0] OFF_LINK     = 8'h24;
  localparam logic [7:0] OFF_EA       = 8'h28;
  localparam logic [7:0] OFF_OPERAND  = 8'h2C;

  // Control register fields (status doubleword bits mirrored here)
  localparam int CTRL_MAP_EN   = 0;
  localparam int CTRL_ALTERED  = 1;
  localparam int CTRL_EXT_LO   = 2;
  localparam int CTRL_EXT_HI   = 7;
  localparam int CTRL_SIZE_LO  = 8;
  localparam int CTRL_SIZE_HI  = 9;
  localparam int CTRL_IMM      = 10;
  localparam int CTRL_WIDTH    = 11;
  localparam logic [10:0] CTRL_RESET = 11'h000;

  // Instruction word fields, bit 31 of the word is the MSB
  localparam int IW_INDIRECT = 31;
  localparam int IW_OP_HI    = 30;
  localparam int IW_OP_LO    = 24;
  localparam int IW_REG_HI   = 23;
  localparam int IW_REG_LO   = 20;
  localparam int IW_X_HI     = 19;
  localparam int IW_X_LO     = 17;
  localparam int IW_ESEL     = 16;
  localparam int IW_IMM_HI   = 19;

  // Map load data fields
  localparam int MAP_IDX_LO  = 16;
  localparam int MAP_IDX_HI  = 23;
  localparam int MAP_ENTRIES = 256;
  localparam int MAP_W       = 13;
  localparam int MAP_OLD_W   = 8;

  // Address widths
  localparam int REAL_WA_W   = 17;
  localparam int EXT_WA_W    = 22;
  localparam int PAGE_OFF_W  = 9;
  localparam int REGION_W    = 16;
  localparam int BYTE_REAL_W = 19;
  localparam int BYTE_EXT_W  = 24;

endpackage : amt_pkg

/* File: testbench/address_mode_translation_tb.sv */
`timescale 1ns/1ps

module address_mode_translation_tb;
  logic        sys_clk_i;
  logic        rst_n_i;
  logic        wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        wb_ack_o, indexed_o, low_region;
  logic [21:0] mem_addr_o;
  logic [1:0]  mem_byte_o, mode_o;
  logic [31:0] operand_o, r, q;
  logic [10:0] ctrl_m;
  logic [31:0] instr_m, idx_m, ind_m;
  logic [12:0] map_m [256];
  logic [23:0] e;
  logic [7:0]  offs [4];
  logic [31:0] msk;
  int          failures, comparisons;

  amt_address_translate amt_address_translate_i (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_addr_o(mem_addr_o), .mem_byte_o(mem_byte_o),
    .mode_o(mode_o), .indexed_o(indexed_o), .operand_o(operand_o));

  amt_core_mem amt_core_mem_i (.mem_addr_i(mem_addr_o), .low_region_o(low_region));

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Classic single cycle; ack and read data are taken at the rising edge that sees ack high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    int n;
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      failures++;
      $display("BAD wb_ack_o expected 1 seen %b", wb_ack_o);
      wrap_up();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    wb(1'b1, a, d, dummy);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] got;
    wb(1'b0, a, 32'h0, got);
    chk(nm, exp, got);
  endtask : rd_chk

  function automatic logic [1:0] mode_m();
    return ctrl_m[0] ? 2'b01 : (ctrl_m[1] ? 2'b10 : 2'b00);
  endfunction : mode_m

  function automatic logic [23:0] model_ea();
    logic [31:0] w;
    logic [31:0] la;
    logic [21:0] base;
    w = instr_m[31] ? ind_m : instr_m;
    if (mode_m() == 2'b10 && instr_m[31] && !ind_m[31]) base = ind_m[21:0];
    else if (mode_m() == 2'b10) base = w[16] ? {ctrl_m[7:2], w[15:0]} : {6'h00, w[15:0]};
    else base = {5'h00, w[16:0]};
    la = {8'h00, base, 2'b00} + ((instr_m[19:17] != 3'h0) ? (idx_m << ctrl_m[9:8]) : 32'h0);
    la = la & ((mode_m() == 2'b10) ? 32'h00FFFFFF : 32'h0007FFFF);
    if (mode_m() == 2'b01) return {map_m[la[18:11]], la[10:2], la[1:0]};
    return la[23:0];
  endfunction : model_ea

  initial begin
    rst_n_i = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    failures = 0;
    comparisons = 0;
    offs = '{amt_pkg::OFF_STACK, amt_pkg::OFF_STR_SRC, amt_pkg::OFF_STR_DST, amt_pkg::OFF_LINK};
    r = $urandom(53);
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(negedge sys_clk_i);
    chk("mode_o reset", 32'h0, {30'h0, mode_o});
    rd_chk("ctrl reset", amt_pkg::OFF_CTRL, 32'h0);
    // Map is not reset, so every entry is loaded before mapped use
    for (int i = 0; i < 256; i++) begin
      r = $urandom;
      map_m[i] = r[12:0];
      wr(amt_pkg::OFF_MAP_FULL, {8'h00, i[7:0], 3'h0, r[12:0]});
    end
    for (int it = 0; it < 80; it++) begin
      r = $urandom;
      ctrl_m = {r[10:2], it[1:0]};
      instr_m = $urandom;
      idx_m = $urandom;
      ind_m = $urandom;
      // First passes pin the unindexed direct and full indirect forms
      if (it < 8) begin
        instr_m[19:17] = 3'h0;
        instr_m[31] = it[2];
        ind_m[31] = 1'b0;
      end
      r = $urandom;
      if (r[31]) map_m[r[23:16]] = {5'h00, r[7:0]};
      else map_m[r[23:16]] = r[12:0];
      wr(r[31] ? amt_pkg::OFF_MAP_OLD : amt_pkg::OFF_MAP_FULL, r);
      wr(amt_pkg::OFF_CTRL, {21'h0, ctrl_m});
      wr(amt_pkg::OFF_INSTR, instr_m);
      wr(amt_pkg::OFF_INDEX, idx_m);
      wr(amt_pkg::OFF_INDIRECT, ind_m);
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      e = model_ea();
      chk("mode_o", {30'h0, mode_m()}, {30'h0, mode_o});
      chk("indexed_o", {31'h0, instr_m[19:17] != 3'h0}, {31'h0, indexed_o});
      chk("operand_o", ctrl_m[10] ? {{12{instr_m[19]}}, instr_m[19:0]} : 32'h0, operand_o);
      if (!ctrl_m[10]) begin
        chk("mem_addr", {8'h00, e}, {8'h00, mem_addr_o, mem_byte_o});
        if (mode_m() == 2'b00) chk("low_region", 32'h1, {31'h0, low_region});
        rd_chk("ea", amt_pkg::OFF_EA, {4'h0, mode_m(), instr_m[19:17] != 3'h0, 1'b0, e});
      end
      for (int k = 0; k < 4; k++) begin
        r = $urandom;
        if (k == 1 || k == 2) msk = (mode_m() == 2'b10) ? 32'h00FFFFFF : 32'h0007FFFF;
        else msk = (mode_m() == 2'b10) ? 32'h003FFFFF : 32'h0001FFFF;
        wr(offs[k], r);
        rd_chk("wide reg", offs[k], r & msk);
      end
    end
    // Read-only and unmapped places keep their contents
    wr(amt_pkg::OFF_EA, 32'hFFFFFFFF);
    if (!ctrl_m[10]) rd_chk("ea ro", amt_pkg::OFF_EA, {4'h0, mode_m(), instr_m[19:17] != 3'h0, 1'b0, e});
    wr(8'h30, 32'hA5A5A5A5);
    rd_chk("unmapped", 8'h30, 32'h0);
    rd_chk("map read", amt_pkg::OFF_MAP_FULL, 32'h0);
    // Only the enabled byte lane may change
    wb_sel_i <= 4'h1;
    wr(amt_pkg::OFF_INDEX, 32'hFFFFFFFF);
    wb_sel_i <= 4'hF;
    rd_chk("sel lanes", amt_pkg::OFF_INDEX, {idx_m[31:8], 8'hFF});
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(negedge sys_clk_i);
    chk("mode_o rerst", 32'h0, {30'h0, mode_o});
    chk("mem_addr rerst", 32'h0, {10'h0, mem_addr_o});
    rd_chk("ctrl rerst", amt_pkg::OFF_CTRL, 32'h0);
    wrap_up();
  end
endmodule : address_mode_translation_tb

/* File: testbench/amt_core_mem.sv */
`timescale 1ns/1ps

// Core memory seen from the address side: flags words in the lowest 128K
module amt_core_mem #(
  parameter logic [21:0] LOW_WORDS = 22'h020000
) (
  // Address from the translator
  input  wire logic [21:0] mem_addr_i,
  // Region report
  output logic             low_region_o
);
  // Plain real references must never leave this region
  assign low_region_o = (mem_addr_i < LOW_WORDS);
endmodule : amt_core_mem

/* File: verilog/amt_address_translate.sv */
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps

module amt_address_translate (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Memory address side
  output logic      [21:0] mem_addr_o,
  output logic      [1:0]  mem_byte_o,
  output logic      [1:0]  mode_o,
  output logic             indexed_o,
  output logic      [31:0] operand_o
);

  logic [10:0] ctrl_reg;
  logic [31:0] instr_reg;
  logic [31:0] index_reg;
  logic [31:0] indirect_reg;
  logic [31:0] stack_reg;
  logic [31:0] src_reg;
  logic [31:0] dst_reg;
  logic [31:0] link_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [21:0] mem_addr_reg;
  logic [1:0]  mem_byte_reg;
  logic [1:0]  mode_reg;
  logic        indexed_reg;
  logic [31:0] operand_reg;
  logic [12:0] map_mem [amt_pkg::MAP_ENTRIES];

  logic        bus_req;
  logic        bus_wr;
  logic [31:0] wmask;
  amt_pkg::amt_mode_e mode_next;
  logic [5:0]  ext_field;
  logic [21:0] base_wa;
  logic [23:0] disp_b;
  logic [23:0] la;
  logic [21:0] mem_addr_next;
  logic        indexed_next;
  logic [31:0] operand_next;
  logic [31:0] rdata_next;
  logic [31:0] ctrl_merged;
  logic        is_ext;

  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign bus_wr  = bus_req & wb_we_i;
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [31:0] m);
    merge = (old & ~m) | (dat & m);
  endfunction : merge

  // Control writes use the same lane merge; only the low control bits are kept
  assign ctrl_merged = merge({21'h000000, ctrl_reg}, wb_dat_i, wmask);

  // A 17-bit address in extended mode: selector bit picks region zero or the extension region
  function automatic logic [21:0] widen17(input logic [16:0] a, input logic [5:0] ext);
    widen17 = a[amt_pkg::IW_ESEL] ? {ext, a[15:0]} : {6'h00, a[15:0]};
  endfunction : widen17

  // Mode selection; map enable overrides the mode-altered bit
  always_comb begin
    if (ctrl_reg[amt_pkg::CTRL_MAP_EN]) begin
      mode_next = amt_pkg::AMT_VIRTUAL;
    end else if (ctrl_reg[amt_pkg::CTRL_ALTERED]) begin
      mode_next = amt_pkg::AMT_EXTENDED;
    end else begin
      mode_next = amt_pkg::AMT_REAL;
    end
  end

  assign is_ext    = (mode_next == amt_pkg::AMT_EXTENDED);
  assign ext_field = ctrl_reg[amt_pkg::CTRL_EXT_HI:amt_pkg::CTRL_EXT_LO];

  // Base word address: instruction field or indirect word
  always_comb begin
    base_wa = {5'h00, instr_reg[16:0]};
    if (instr_reg[amt_pkg::IW_INDIRECT]) begin
      if (!is_ext) begin
        base_wa = {5'h00, indirect_reg[16:0]};
      end else if (!indirect_reg[31]) begin
        base_wa = indirect_reg[21:0];
      end else begin
        base_wa = widen17(indirect_reg[16:0], ext_field);
      end
    end else if (is_ext) begin
      base_wa = widen17(instr_reg[16:0], ext_field);
    end
  end

  // Displacement aligned to operand size; the width mask below drops the excess high bits
  assign indexed_next = (instr_reg[amt_pkg::IW_X_HI:amt_pkg::IW_X_LO] != 3'h0);

  always_comb begin
    disp_b = 24'h000000;
    if (indexed_next) begin
      case (ctrl_reg[amt_pkg::CTRL_SIZE_HI:amt_pkg::CTRL_SIZE_LO])
        2'b00:   disp_b = index_reg[23:0];
        2'b01:   disp_b = {index_reg[22:0], 1'b0};
        2'b10:   disp_b = {index_reg[21:0], 2'b00};
        default: disp_b = {index_reg[20:0], 3'b000};
      endcase
    end
  end

  // Byte address: 24 bits when extended, 19 bits otherwise
  always_comb begin
    la = {base_wa, 2'b00} + disp_b;
    if (!is_ext) begin
      la = {5'h00, la[18:0]};
    end
  end

  // Final word address per addressing type
  always_comb begin
    case (mode_next)
      amt_pkg::AMT_VIRTUAL:  mem_addr_next = {map_mem[la[18:11]], la[10:2]};
      amt_pkg::AMT_EXTENDED: mem_addr_next = la[23:2];
      amt_pkg::AMT_REAL:     mem_addr_next = {5'h00, la[18:2]};
      default:               mem_addr_next = {5'h00, la[18:2]};
    endcase
  end

  // Immediate operand: index and address fields as one signed value
  assign operand_next = ctrl_reg[amt_pkg::CTRL_IMM] ?
                        {{12{instr_reg[amt_pkg::IW_IMM_HI]}}, instr_reg[19:0]} : 32'h00000000;

  // Register writes
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg     <= amt_pkg::CTRL_RESET;
      instr_reg    <= 32'h00000000;
      index_reg    <= 32'h00000000;
      indirect_reg <= 32'h00000000;
      stack_reg    <= 32'h00000000;
      src_reg      <= 32'h00000000;
      dst_reg      <= 32'h00000000;
      link_reg     <= 32'h00000000;
    end else if (bus_wr) begin
      case (wb_adr_i)
        amt_pkg::OFF_CTRL:     ctrl_reg     <= ctrl_merged[10:0];
        amt_pkg::OFF_INSTR:    instr_reg    <= merge(instr_reg, wb_dat_i, wmask);
        amt_pkg::OFF_INDEX:    index_reg    <= merge(index_reg, wb_dat_i, wmask);
        amt_pkg::OFF_INDIRECT: indirect_reg <= merge(indirect_reg, wb_dat_i, wmask);
        amt_pkg::OFF_STACK:    stack_reg    <= merge(stack_reg, wb_dat_i, wmask);
        amt_pkg::OFF_STR_SRC:  src_reg      <= merge(src_reg, wb_dat_i, wmask);
        amt_pkg::OFF_STR_DST:  dst_reg      <= merge(dst_reg, wb_dat_i, wmask);
        amt_pkg::OFF_LINK:     link_reg     <= merge(link_reg, wb_dat_i, wmask);
        default: ;
      endcase
    end
  end

  // Map storage has no reset: contents are undefined until software loads them
  always_ff @(posedge sys_clk_i) begin
    if (bus_wr && wb_adr_i == amt_pkg::OFF_MAP_OLD) begin
      map_mem[wb_dat_i[amt_pkg::MAP_IDX_HI:amt_pkg::MAP_IDX_LO]] <= {5'h00, wb_dat_i[7:0]};
    end else if (bus_wr && wb_adr_i == amt_pkg::OFF_MAP_FULL) begin
      map_mem[wb_dat_i[amt_pkg::MAP_IDX_HI:amt_pkg::MAP_IDX_LO]] <= wb_dat_i[12:0];
    end
  end

  // Read data; stack, string source/destination and link registers read back at the width of the current addressing type
  always_comb begin
    rdata_next = 32'h00000000;
    case (wb_adr_i)
      amt_pkg::OFF_CTRL:     rdata_next = {21'h000000, ctrl_reg};
      amt_pkg::OFF_INSTR:    rdata_next = instr_reg;
      amt_pkg::OFF_INDEX:    rdata_next = index_reg;
      amt_pkg::OFF_INDIRECT: rdata_next = indirect_reg;
      amt_pkg::OFF_STACK:    rdata_next = is_ext ? {10'h000, stack_reg[21:0]}
                                                 : {15'h0000, stack_reg[16:0]};
      amt_pkg::OFF_STR_SRC:  rdata_next = is_ext ? {8'h00, src_reg[23:0]}
                                                 : {13'h0000, src_reg[18:0]};
      amt_pkg::OFF_STR_DST:  rdata_next = is_ext ? {8'h00, dst_reg[23:0]}
                                                 : {13'h0000, dst_reg[18:0]};
      amt_pkg::OFF_LINK:     rdata_next = is_ext ? {10'h000, link_reg[21:0]}
                                                 : {15'h0000, link_reg[16:0]};
      amt_pkg::OFF_EA:       rdata_next = {4'h0, mode_reg, indexed_reg, 1'b0, mem_addr_reg, mem_byte_reg};
      amt_pkg::OFF_OPERAND:  rdata_next = operand_reg;
      default:               rdata_next = 32'h00000000;
    endcase
  end

  // Bus answer: one wait state, ack for exactly one cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg   <= bus_req;
      rdata_reg <= bus_req ? rdata_next : 32'h00000000;
    end
  end

  // Translation results, refreshed every cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_addr_reg <= 22'h000000;
      mem_byte_reg <= 2'b00;
      mode_reg     <= amt_pkg::AMT_REAL;
      indexed_reg  <= 1'b0;
      operand_reg  <= 32'h00000000;
    end else begin
      mem_addr_reg <= mem_addr_next;
      mem_byte_reg <= la[1:0];
      mode_reg     <= mode_next;
      indexed_reg  <= indexed_next;
      operand_reg  <= operand_next;
    end
  end

  assign wb_ack_o   = ack_reg;
  assign wb_dat_o   = rdata_reg;
  assign mem_addr_o = mem_addr_reg;
  assign mem_byte_o = mem_byte_reg;
  assign mode_o     = mode_reg;
  assign indexed_o  = indexed_reg;
  assign operand_o  = operand_reg;

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_map_old_write;
    bus_wr && wb_adr_i == amt_pkg::OFF_MAP_OLD;
  endsequence

  sequence s_map_full_write;
    bus_wr && wb_adr_i == amt_pkg::OFF_MAP_FULL;
  endsequence

  a_real_upper_zero: assert property (
    mode_o == amt_pkg::AMT_REAL |-> mem_addr_o[21:17] == 5'h00)
    else $error("real address has upper bits set");

  a_map_priority: assert property (
    ctrl_reg[amt_pkg::CTRL_MAP_EN] |=> mode_o == amt_pkg::AMT_VIRTUAL)
    else $error("map enable did not select mapped addressing");

  a_ext_select: assert property (
    !ctrl_reg[amt_pkg::CTRL_MAP_EN] && ctrl_reg[amt_pkg::CTRL_ALTERED] |=> mode_o == amt_pkg::AMT_EXTENDED)
    else $error("extended addressing not selected");

  a_map_old_load: assert property (
    s_map_old_write |=> map_mem[$past(wb_dat_i[23:16])] == {5'h00, $past(wb_dat_i[7:0])})
    else $error("compatible map load wrong");

  a_map_full_load: assert property (
    s_map_full_write |=> map_mem[$past(wb_dat_i[23:16])] == $past(wb_dat_i[12:0]))
    else $error("full map load wrong");

  a_virt_offset: assert property (
    mode_next == amt_pkg::AMT_VIRTUAL |=> mem_addr_o[8:0] == $past(la[10:2]))
    else $error("page offset not carried through map");

  a_no_index: assert property (
    !indexed_next && !instr_reg[31] && mode_next == amt_pkg::AMT_REAL |=> mem_addr_o == {5'h00, $past(instr_reg[16:0])})
    else $error("address changed without indexing");

  a_ind_full: assert property (
    is_ext && instr_reg[31] && !indirect_reg[31] && !indexed_next |=> mem_addr_o == $past(indirect_reg[21:0]))
    else $error("full indirect address wrong");

  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // Extended-mode read of a widened pointer register
  sequence s_ext_read(logic [7:0] off);
    bus_req && !wb_we_i && is_ext && wb_adr_i == off;
  endsequence

  a_ack_answer: assert property (
    bus_req |=> wb_ack_o)
    else $error("request not answered in the next cycle");

  a_rdata_idle: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data not zero outside ack");

  a_ext_low_region: assert property (
    is_ext && !instr_reg[amt_pkg::IW_INDIRECT] && !instr_reg[amt_pkg::IW_ESEL] && !indexed_next
    |=> mem_addr_o == {6'h00, $past(instr_reg[15:0])})
    else $error("region zero address wrong");

  a_ext_high_region: assert property (
    is_ext && !instr_reg[amt_pkg::IW_INDIRECT] && instr_reg[amt_pkg::IW_ESEL] && !indexed_next
    |=> mem_addr_o == {$past(ext_field), $past(instr_reg[15:0])})
    else $error("extension field not prefixed");

  a_ind_short: assert property (
    is_ext && instr_reg[amt_pkg::IW_INDIRECT] && indirect_reg[31] && !indexed_next
    |=> mem_addr_o[15:0] == $past(indirect_reg[15:0])
        && mem_addr_o[21:16] == ($past(indirect_reg[16]) ? $past(ext_field) : 6'h00))
    else $error("short indirect address wrong");

  a_imm_operand: assert property (
    ctrl_reg[amt_pkg::CTRL_IMM] |=> operand_o[19:0] == $past(instr_reg[19:0])
    && operand_o[31:20] == {12{$past(instr_reg[amt_pkg::IW_IMM_HI])}})
    else $error("immediate operand wrong");

  a_imm_off: assert property (
    !ctrl_reg[amt_pkg::CTRL_IMM] |=> operand_o == 32'h00000000)
    else $error("operand shown without immediate opcode");

  a_alt_ignored: assert property (
    ctrl_reg[amt_pkg::CTRL_MAP_EN] && ctrl_reg[amt_pkg::CTRL_ALTERED] |=> mode_o == amt_pkg::AMT_VIRTUAL)
    else $error("mode-altered bit changed mapped addressing");

  a_real_select: assert property (
    !ctrl_reg[amt_pkg::CTRL_MAP_EN] && !ctrl_reg[amt_pkg::CTRL_ALTERED] |=> mode_o == amt_pkg::AMT_REAL)
    else $error("plain real addressing not selected");

  a_index_set: assert property (
    instr_reg[amt_pkg::IW_X_HI:amt_pkg::IW_X_LO] != 3'h0 |=> indexed_o)
    else $error("index select not flagged");

  a_index_clear: assert property (
    instr_reg[amt_pkg::IW_X_HI:amt_pkg::IW_X_LO] == 3'h0 |=> !indexed_o)
    else $error("indexing flagged without index select");

  a_ext_word_disp: assert property (
    is_ext && indexed_next && ctrl_reg[amt_pkg::CTRL_SIZE_HI:amt_pkg::CTRL_SIZE_LO] == 2'b10
    |=> mem_addr_o == $past(base_wa + index_reg[21:0]) && mem_byte_o == 2'b00)
    else $error("extended word displacement wrong");

  a_ext_byte_disp: assert property (
    is_ext && indexed_next && ctrl_reg[amt_pkg::CTRL_SIZE_HI:amt_pkg::CTRL_SIZE_LO] == 2'b00
    |=> {mem_addr_o, mem_byte_o} == $past({base_wa, 2'b00} + index_reg[23:0]))
    else $error("extended byte displacement wrong");

  a_real_byte_disp: assert property (
    mode_next == amt_pkg::AMT_REAL && indexed_next && ctrl_reg[amt_pkg::CTRL_SIZE_HI:amt_pkg::CTRL_SIZE_LO] == 2'b00
    |=> {mem_addr_o, mem_byte_o} == {5'h00, $past({base_wa[16:0], 2'b00} + index_reg[18:0])})
    else $error("real byte address left the low region");

  a_map_entry: assert property (
    mode_next == amt_pkg::AMT_VIRTUAL |=> mem_addr_o[21:9] == $past(map_mem[la[18:11]]))
    else $error("page not taken from map entry");

  a_stack_wide: assert property (
    s_ext_read(amt_pkg::OFF_STACK) |=> wb_dat_o == {10'h000, $past(stack_reg[21:0])})
    else $error("stack pointer not 22 bits");

  a_link_wide: assert property (
    s_ext_read(amt_pkg::OFF_LINK) |=> wb_dat_o == {10'h000, $past(link_reg[21:0])})
    else $error("link address not 22 bits");

  a_str_wide: assert property (
    s_ext_read(amt_pkg::OFF_STR_SRC) |=> wb_dat_o == {8'h00, $past(src_reg[23:0])})
    else $error("string source not 24 bits");

endmodule : amt_address_translate
